// [src/ext_irq_pkg.sv]
// shared constants, register map and types of the external interrupt front end
package ext_irq_pkg;

    // ------------------------------------------------------------------
    // register map: printed offsets are register indices, byte address = 4 * index
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_EXT_IRQ_CONTROL = 8'h37;
    localparam logic [7:0] IDX_IRQ_ENABLE      = 8'h38;
    localparam logic [7:0] IDX_IRQ_LATCH       = 8'h39;
    localparam logic [7:0] IDX_MODE_CONFIG     = 8'h3A;
    localparam logic [7:0] IDX_TRAP_STATUS     = 8'h3B;
    localparam int         ADDR_W              = 10;

    localparam logic [7:0] EXT_IRQ_CONTROL_RST = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_RST      = 8'h00;
    localparam logic [7:0] MODE_CONFIG_RST     = 8'h00;

    // ext_irq_control fields
    localparam int CTL_FILTER_SEL = 7;
    localparam int CTL_FUNC_SEL   = 6;
    localparam int CTL_TRIG_HI    = 5;
    localparam int CTL_TRIG_LO    = 4;
    localparam int CTL_EDGE_D     = 3;
    localparam int CTL_EDGE_C     = 2;
    localparam int CTL_EDGE_B     = 1;

    // irq_enable fields: bit 0 master, bits 1..6 source enables 4,5,8,11,14,15
    localparam int EN_MASTER = 0;
    localparam int EN_SRC_LO = 1;

    // mode_config fields
    localparam int CFG_SLOW      = 0;
    localparam int CFG_SHARED_14 = 1;
    localparam int CFG_SHARED_15 = 2;
    localparam int CFG_TRAP_IRQ  = 3;

    // ------------------------------------------------------------------
    // latch order: 0..5 = request latches 4,5,8,11,14,15
    // ------------------------------------------------------------------
    localparam int NUM_PINS = 6;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int PIN_D = 3;
    localparam int PIN_E = 4;
    localparam int PIN_F = 5;

    localparam logic [1:0] TRIG_RISE  = 2'b00;
    localparam logic [1:0] TRIG_FALL  = 2'b01;
    localparam logic [1:0] TRIG_BOTH  = 2'b10;
    localparam logic [1:0] TRIG_LEVEL = 2'b11;

    // ------------------------------------------------------------------
    // filter timing, in periods of the main clock and of the sub clock
    // ------------------------------------------------------------------
    localparam int CLK_PER_FC     = 1;   // the block clock is the main clock
    localparam int FAST_REJ_FC    = 2;   // pins a, f: reject < 2, accept >= 7
    localparam int FAST_ACC_FC    = 7;
    localparam int MID_REJ_FC     = 7;   // pins c, d, e: reject < 7, accept >= 25
    localparam int MID_ACC_FC     = 25;
    localparam int B_SHORT_REJ_FC = 15;  // pin b short: reject < 15, accept >= 49
    localparam int B_SHORT_ACC_FC = 49;
    localparam int B_LONG_REJ_FC  = 63;  // pin b long: reject < 63, accept >= 193
    localparam int B_LONG_ACC_FC  = 193;
    localparam int SLOW_ACC_FS    = 3;   // reject < 1/fs, accept >= 3/fs

    // stable count sits between the two figures
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_FAST =
        CNT_W'(((FAST_REJ_FC + FAST_ACC_FC) / 2) * CLK_PER_FC);
    localparam logic [CNT_W-1:0] CNT_MID =
        CNT_W'(((MID_REJ_FC + MID_ACC_FC) / 2) * CLK_PER_FC);
    localparam logic [CNT_W-1:0] CNT_B_SHORT =
        CNT_W'(((B_SHORT_REJ_FC + B_SHORT_ACC_FC) / 2) * CLK_PER_FC);
    localparam logic [CNT_W-1:0] CNT_B_LONG =
        CNT_W'(((B_LONG_REJ_FC + B_LONG_ACC_FC) / 2) * CLK_PER_FC);
    localparam logic [CNT_W-1:0] CNT_SLOW = CNT_W'(SLOW_ACC_FS - 1);

    // synchroniser depth plus one cycle before edges count after reset
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;

    typedef struct packed {
        logic       filter_short;
        logic       func_sel;
        logic [1:0] trig_e;
        logic       edge_d;
        logic       edge_c;
        logic       edge_b;
    } ctl_type;

    typedef struct packed {
        logic trap_irq;
        logic shared_15;
        logic shared_14;
        logic slow;
    } cfg_type;

endpackage

// [src/ext_irq_filter_trap_logic.sv]
// external interrupt filter, trigger select, request latches and trap raising
`timescale 1ns/1ps
`default_nettype none

module ext_irq_filter_trap_logic
    import ext_irq_pkg::*;
#(
    parameter int SUB_DIV = 6   // main clocks per sub-clock period
) (
    input  wire logic              clk_i,               // 200 MHz main clock
    input  wire logic              rst_i,               // synchronous reset, high
    // classic wishbone slave
    input  wire logic              wb_cyc_i,            // bus cycle
    input  wire logic              wb_stb_i,            // strobe
    input  wire logic              wb_we_i,             // write
    input  wire logic [ADDR_W-1:0] wb_adr_i,            // byte address
    input  wire logic [3:0]        wb_sel_i,            // byte enables
    input  wire logic [31:0]       wb_dat_i,            // write data
    output logic      [31:0]       wb_dat_o,            // read data
    output logic                   wb_ack_o,            // acknowledge
    // pins and neighbours
    input  wire logic [5:0]        ext_irq_pin_i,       // pins a..f, asynchronous
    input  wire logic              converter_done_irq_i,// converter done pulse
    input  wire logic              shared_14_src_i,     // other source of latch 14
    input  wire logic              bad_opcode_i,        // core executes undefined code
    input  wire logic              fetch_area_fault_i,  // fetch from forbidden area
    input  wire logic              accept_i,            // core accepts maskable source
    input  wire logic [2:0]        accept_src_i,        // latch index accepted
    input  wire logic              trap_accept_i,       // core accepts pending trap
    // to the core
    output logic      [5:0]        irq_request_o,       // enabled pending sources
    output logic                   bad_opcode_trap_o,   // trap pending, unmaskable
    output logic                   fetch_area_trap_o,   // trap pending, unmaskable
    output logic                   abort_current_o,     // break current service
    output logic                   reset_request_o,     // trap-reset pulse
    output logic                   pin_a_is_irq_o       // 0: pin a is a port pin
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    ctl_type    ctl;
    cfg_type    cfg;
    logic [7:0] irq_enable;
    logic [5:0] request_latch;
    logic       bad_opcode_pend;
    logic       fetch_area_pend;

    logic       sub_tick;
    logic [7:0] sub_cnt;
    logic [1:0] settle_cnt;
    logic       settled;

    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] filt;
    logic [5:0] filt_prev;
    logic [5:0] rise;
    logic [5:0] fall;
    logic [5:0] hit;
    logic       level_armed;

    function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        is_reg = (a == {idx, 2'b00});
    endfunction

    // ------------------------------------------------------------------
    // wishbone slave: one wait state, ack dropped after one cycle
    // ------------------------------------------------------------------
    logic wb_req;
    logic wb_wr;
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req) begin
            wb_dat_o <= 32'h0000_0000;
            if (is_reg(wb_adr_i, IDX_EXT_IRQ_CONTROL)) begin
                wb_dat_o[7:1] <= ctl;   // bit 0 reads zero
            end else if (is_reg(wb_adr_i, IDX_IRQ_ENABLE)) begin
                wb_dat_o[6:0] <= irq_enable[6:0];
            end else if (is_reg(wb_adr_i, IDX_IRQ_LATCH)) begin
                wb_dat_o[5:0] <= request_latch;
            end else if (is_reg(wb_adr_i, IDX_MODE_CONFIG)) begin
                wb_dat_o[3:0] <= cfg;
            end else if (is_reg(wb_adr_i, IDX_TRAP_STATUS)) begin
                wb_dat_o[1:0] <= {fetch_area_pend, bad_opcode_pend};
            end
        end
    end

    // new filter select reaches the counters at once, well inside 64 clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl <= ctl_type'(EXT_IRQ_CONTROL_RST[7:1]);
        end else if (wb_wr && is_reg(wb_adr_i, IDX_EXT_IRQ_CONTROL)) begin
            ctl <= ctl_type'(wb_dat_i[7:1]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg <= cfg_type'(MODE_CONFIG_RST[3:0]);
        end else if (wb_wr && is_reg(wb_adr_i, IDX_MODE_CONFIG)) begin
            cfg <= cfg_type'(wb_dat_i[3:0]);
        end
    end

    // acceptance clears master enable; a software write in the same cycle loses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_enable <= IRQ_ENABLE_RST;
        end else begin
            if (wb_wr && is_reg(wb_adr_i, IDX_IRQ_ENABLE)) begin
                irq_enable <= {1'b0, wb_dat_i[6:0]};
            end
            if (accept_i) begin
                irq_enable[EN_MASTER] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // sub-clock enable and post-reset settling
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sub_cnt  <= 8'h00;
            sub_tick <= 1'b0;
        end else begin
            sub_tick <= (sub_cnt == 8'(SUB_DIV - 1));
            sub_cnt  <= (sub_cnt == 8'(SUB_DIV - 1)) ? 8'h00 : sub_cnt + 8'h01;
        end
    end

    // the first level seen after reset is taken silently, no edge from it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settle_cnt <= 2'h0;
            settled    <= 1'b0;
        end else if (!settled) begin
            settle_cnt <= settle_cnt + 2'h1;
            settled    <= (settle_cnt == SETTLE_CYCLES - 2'h1);
        end
    end

    // ------------------------------------------------------------------
    // synchroniser and noise filters
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
        end else begin
            sync1 <= ext_irq_pin_i;
            sync2 <= sync1;
        end
    end

    function automatic logic [CNT_W-1:0] stable_count(input int pin, input logic slow,
                                                      input logic b_short);
        if (slow) begin
            stable_count = CNT_SLOW;
        end else if (pin == PIN_A || pin == PIN_F) begin
            stable_count = CNT_FAST;
        end else if (pin == PIN_B) begin
            stable_count = b_short ? CNT_B_SHORT : CNT_B_LONG;
        end else begin
            stable_count = CNT_MID;
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : gen_filter
            logic [CNT_W-1:0] cnt;
            logic [CNT_W-1:0] limit;
            logic             step;
            assign limit = stable_count(g, cfg.slow, ctl.filter_short);
            assign step  = cfg.slow ? sub_tick : 1'b1;

            // short pulses restart the count and never reach the output
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cnt     <= '0;
                    filt[g] <= 1'b0;
                end else if (!settled) begin
                    cnt     <= '0;
                    filt[g] <= sync2[g];
                end else if (sync2[g] == filt[g]) begin
                    cnt <= '0;
                end else if (step) begin
                    if (cnt + CNT_W'(1) >= limit) begin
                        cnt     <= '0;
                        filt[g] <= sync2[g];
                    end else begin
                        cnt <= cnt + CNT_W'(1);
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_prev <= 6'h00;
        end else if (!settled) begin
            filt_prev <= sync2;  // the level taken at release must not look like an edge
        end else begin
            filt_prev <= filt;
        end
    end

    assign rise = settled ? (filt & ~filt_prev) : 6'h00;
    assign fall = settled ? (~filt & filt_prev) : 6'h00;

    // ------------------------------------------------------------------
    // trigger selection
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_armed <= 1'b0;
        end else if (rise[PIN_E]) begin
            level_armed <= 1'b1;
        end
    end

    always_comb begin
        hit        = 6'h00;
        hit[PIN_A] = fall[PIN_A] & ctl.func_sel;
        hit[PIN_B] = ctl.edge_b ? fall[PIN_B] : rise[PIN_B];
        hit[PIN_C] = ctl.edge_c ? fall[PIN_C] : rise[PIN_C];
        hit[PIN_D] = ctl.edge_d ? fall[PIN_D] : rise[PIN_D];
        case (ctl.trig_e)
            TRIG_RISE:  hit[PIN_E] = rise[PIN_E];
            TRIG_FALL:  hit[PIN_E] = fall[PIN_E];
            TRIG_BOTH:  hit[PIN_E] = rise[PIN_E] | fall[PIN_E];
            TRIG_LEVEL: hit[PIN_E] = filt[PIN_E] & level_armed;
            default:    hit[PIN_E] = 1'b0;
        endcase
        if (cfg.shared_14) begin
            hit[PIN_E] = shared_14_src_i;
        end
        hit[PIN_F] = cfg.shared_15 ? converter_done_irq_i : fall[PIN_F];
    end

    // ------------------------------------------------------------------
    // request latches: set beats acceptance and software clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            request_latch <= 6'h00;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (hit[i]) begin
                    request_latch[i] <= 1'b1;
                end else if (accept_i && accept_src_i == 3'(i)) begin
                    request_latch[i] <= 1'b0;
                end else if (wb_wr && is_reg(wb_adr_i, IDX_IRQ_LATCH) && wb_dat_i[i]) begin
                    request_latch[i] <= 1'b0;
                end
            end
        end
    end

    // software masks sources around clock switches and pin direction changes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_request_o <= 6'h00;
        end else begin
            irq_request_o <= request_latch & irq_enable[EN_SRC_LO +: NUM_PINS]
                             & {NUM_PINS{irq_enable[EN_MASTER]}};
        end
    end

    // ------------------------------------------------------------------
    // traps: no mask, no regard for non-maskable service in progress
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bad_opcode_pend <= 1'b0;
        end else if (bad_opcode_i) begin
            bad_opcode_pend <= 1'b1;
        end else if (trap_accept_i) begin
            bad_opcode_pend <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fetch_area_pend <= 1'b0;
            reset_request_o <= 1'b0;
        end else begin
            reset_request_o <= fetch_area_fault_i & ~cfg.trap_irq;
            if (fetch_area_fault_i && cfg.trap_irq) begin
                fetch_area_pend <= 1'b1;
            end else if (trap_accept_i) begin
                fetch_area_pend <= 1'b0;
            end
        end
    end

    assign bad_opcode_trap_o = bad_opcode_pend;
    assign fetch_area_trap_o = fetch_area_pend;
    assign abort_current_o   = bad_opcode_pend | fetch_area_pend;
    assign pin_a_is_irq_o    = ctl.func_sel;

endmodule

`default_nettype wire

// [dv/ext_irq_monitor.sv]
// port-level assertions of the external interrupt front end
`timescale 1ns/1ps
`default_nettype none
module ext_irq_monitor (
    input wire logic       clk_i,              // main clock
    input wire logic       rst_i,              // sync reset
    input wire logic       bad_opcode_i,       // undefined opcode
    input wire logic       fetch_area_fault_i, // forbidden fetch
    input wire logic       accept_i,           // core accepts
    input wire logic       trap_accept_i,      // core takes trap
    input wire logic [5:0] irq_request_o,      // pending sources
    input wire logic       bad_opcode_trap_o,  // trap pending
    input wire logic       fetch_area_trap_o,  // trap pending
    input wire logic       abort_current_o,    // break service
    input wire logic       reset_request_o,    // trap reset
    input wire logic       pin_a_is_irq_o      // pin a function
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // traps
    // ------------------------------------------------------------
    sequence s_bad_req;
        bad_opcode_i && !trap_accept_i;
    endsequence
    sequence s_fetch_req;
        fetch_area_fault_i && !trap_accept_i;
    endsequence
    property p_bad_raise;
        s_bad_req |=> bad_opcode_trap_o;
    endproperty
    a_bad_raise: assert property (p_bad_raise)
        else $error("bad opcode trap not raised");
    property p_bad_abort;
        bad_opcode_trap_o |-> abort_current_o;
    endproperty
    a_bad_abort: assert property (p_bad_abort)
        else $error("bad opcode trap does not abort");
    property p_trap_stand;
        bad_opcode_trap_o && !trap_accept_i |=> bad_opcode_trap_o;
    endproperty
    a_trap_stand: assert property (p_trap_stand)
        else $error("bad opcode trap dropped unaccepted");
    property p_fetch_either;
        s_fetch_req |=> fetch_area_trap_o || reset_request_o;
    endproperty
    a_fetch_either: assert property (p_fetch_either)
        else $error("fetch fault gave neither trap nor reset");
    property p_pulse_cause;
        reset_request_o |-> $past(fetch_area_fault_i);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause)
        else $error("reset request without fetch fault");
    property p_fetch_abort;
        fetch_area_trap_o |-> abort_current_o;
    endproperty
    a_fetch_abort: assert property (p_fetch_abort)
        else $error("fetch trap does not abort");
    property p_trap_release;
        trap_accept_i && !bad_opcode_i && !fetch_area_fault_i |=> !abort_current_o;
    endproperty
    a_trap_release: assert property (p_trap_release)
        else $error("abort stands after trap accepted");
    // ------------------------------------------------------------
    // maskable requests
    // ------------------------------------------------------------
    property p_port_at_reset;
        $fell(rst_i) |-> !pin_a_is_irq_o && irq_request_o == 6'h00;
    endproperty
    a_port_at_reset: assert property (p_port_at_reset)
        else $error("pin a or requests active after reset");
    property p_accept_clear;
        accept_i |-> ##2 irq_request_o == 6'h00;
    endproperty
    a_accept_clear: assert property (p_accept_clear)
        else $error("requests stand after acceptance");
endmodule
bind ext_irq_filter_trap_logic ext_irq_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i),
    .bad_opcode_i(bad_opcode_i), .fetch_area_fault_i(fetch_area_fault_i),
    .accept_i(accept_i), .trap_accept_i(trap_accept_i), .irq_request_o(irq_request_o),
    .bad_opcode_trap_o(bad_opcode_trap_o), .fetch_area_trap_o(fetch_area_trap_o),
    .abort_current_o(abort_current_o), .reset_request_o(reset_request_o),
    .pin_a_is_irq_o(pin_a_is_irq_o));
`default_nettype wire

// [dv/cpu_accept_model.sv]
// core-side model that accepts pending requests and traps
`timescale 1ns/1ps
`default_nettype none
module cpu_accept_model (
    input  wire logic       clk_i,         // main clock
    input  wire logic       rst_i,         // sync reset
    input  wire logic [3:0] delay_i,       // cycles before accepting
    input  wire logic [5:0] irq_request_i, // pending sources
    input  wire logic       trap_i,        // any trap pending
    output logic            accept_o,      // accept pulse
    output logic [2:0]      accept_src_o,  // accepted latch
    output logic            trap_accept_o  // trap accept pulse
);
    logic [3:0] wait_q;
    logic [2:0] first_src;
    always_comb begin
        first_src = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (irq_request_i[i]) begin
                first_src = 3'(i);
            end
        end
    end
    // a fresh wait after each accept keeps a stale request from being taken twice
    always_ff @(posedge clk_i) begin
        accept_o <= 1'h0;
        trap_accept_o <= 1'h0;
        if (rst_i || !(trap_i || |irq_request_i) || accept_o || trap_accept_o) begin
            wait_q <= 4'h0;
        end else if (wait_q < delay_i) begin
            wait_q <= wait_q + 4'h1;
        end else if (trap_i) begin
            trap_accept_o <= 1'h1;
        end else begin
            accept_o <= 1'h1;
            accept_src_o <= first_src;
        end
    end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench of the external interrupt front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ext_irq_pkg::*;
    logic clk_i, rst_i, cyc, we, ack, cdone, bad, fetch, acc, tacc, bad_t, fetch_t, rq;
    logic [ADDR_W-1:0] adr;
    logic [31:0] wdat, rdat, got;
    logic [5:0] pins, req;
    logic [2:0] asrc;
    logic [3:0] dly;
    int miscompares = 0;
    int check_count = 0;
    ext_irq_filter_trap_logic #(.SUB_DIV(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_irq_pin_i(pins),
        .converter_done_irq_i(cdone), .shared_14_src_i(1'h0), .bad_opcode_i(bad),
        .fetch_area_fault_i(fetch), .accept_i(acc), .accept_src_i(asrc),
        .trap_accept_i(tacc), .irq_request_o(req), .bad_opcode_trap_o(bad_t),
        .fetch_area_trap_o(fetch_t), .abort_current_o(), .reset_request_o(rq),
        .pin_a_is_irq_o());
    cpu_accept_model cpu_u (.clk_i(clk_i), .rst_i(rst_i), .delay_i(dly),
        .irq_request_i(req), .trap_i(bad_t | fetch_t), .accept_o(acc),
        .accept_src_o(asrc), .trap_accept_o(tacc));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // single classic cycle; the master waits up to 50 cycles for ack
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'h1;
        we <= w;
        adr <= {idx, 2'h0};
        wdat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'h1 && ++n < 50);
        if (ack !== 1'h1) miscompares++;
        got = rdat;
        cyc <= 1'h0;
    endtask
    // w = 0 leaves the pin toggled, a step instead of a pulse
    task automatic pulse(input int p, input int w, input logic [7:0] exp);
        @(posedge clk_i);
        pins[p] <= ~pins[p];
        if (w > 0) begin
            repeat (w) @(posedge clk_i);
            pins[p] <= ~pins[p];
        end
        repeat (300) @(posedge clk_i);
        wb(1'h0, IDX_IRQ_LATCH, 8'h00);
        check(got, {24'h0, exp});
        wb(1'h1, IDX_IRQ_LATCH, 8'h3F);
    endtask
    task automatic t_pin_e_modes;
        for (int m = 0; m < 4; m++) begin
            wb(1'h1, IDX_EXT_IRQ_CONTROL, 8'(m << 4));
            pulse(PIN_E, 0, (m == 1) ? 8'h00 : 8'h10);
            pulse(PIN_E, 0, (m == 0) ? 8'h00 : 8'h10);
        end
    endtask
    task automatic t_edge_sel;
        for (int p = 1; p < 4; p++) begin
            for (int s = 0; s < 2; s++) begin
                wb(1'h1, IDX_EXT_IRQ_CONTROL, 8'h80 | 8'(s << p));
                pulse(p, 0, (s == 0) ? 8'(1 << p) : 8'h00);
                pulse(p, 0, (s == 1) ? 8'(1 << p) : 8'h00);
            end
        end
    endtask
    task automatic t_traps;
        wb(1'h1, IDX_MODE_CONFIG, 8'h08);
        @(posedge clk_i);
        bad <= 1'h1;
        @(posedge clk_i);
        bad <= 1'h0;
        wb(1'h0, IDX_TRAP_STATUS, 8'h00);
        check(got, 32'h1);
        repeat (20) @(posedge clk_i);
        check(bad_t, 1'h0);
        fetch <= 1'h1;
        @(posedge clk_i);
        fetch <= 1'h0;
        wb(1'h0, IDX_TRAP_STATUS, 8'h00);
        check(got, 32'h2);
        wb(1'h1, IDX_MODE_CONFIG, 8'h00);
        fetch <= 1'h1;
        @(posedge clk_i);
        fetch <= 1'h0;
        #1 check(rq, 1'h1);
        @(posedge clk_i);
        #1 check(rq, 1'h0);
    endtask
    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        #300us;
        miscompares++;
        stop_test();
    end
    initial begin
        {rst_i, cyc, we, cdone, bad, fetch} = 6'h20;
        adr = '0;
        wdat = '0;
        pins = 6'b110001;
        dly = 4'h9;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, IDX_EXT_IRQ_CONTROL, 8'h00);
        check(got, 32'h0);
        wb(1'h0, 8'h08, 8'h00);
        check(got, 32'h0);
        wb(1'h1, IDX_EXT_IRQ_CONTROL, 8'h30);
        repeat (300) @(posedge clk_i);
        wb(1'h0, IDX_IRQ_LATCH, 8'h00);
        check(got, 32'h0);
        pins[PIN_E] <= 1'h0;
        repeat (30) @(posedge clk_i);
        pulse(PIN_E, 25, 8'h10);
        wb(1'h1, IDX_EXT_IRQ_CONTROL, 8'hFF);
        wb(1'h0, IDX_EXT_IRQ_CONTROL, 8'h00);
        check(got, 32'hFE);
        wb(1'h1, IDX_EXT_IRQ_CONTROL, 8'h00);
        pulse(PIN_A, 7, 8'h00);
        wb(1'h1, IDX_EXT_IRQ_CONTROL, 8'h40);
        pulse(PIN_A, 1, 8'h00);
        pulse(PIN_A, 7, 8'h01);
        pulse(PIN_F, 1, 8'h00);
        pulse(PIN_F, 7, 8'h20);
        pulse(PIN_C, 6, 8'h00);
        pulse(PIN_C, 25, 8'h04);
        pulse(PIN_B, 62, 8'h00);
        pulse(PIN_B, 193, 8'h02);
        wb(1'h1, IDX_EXT_IRQ_CONTROL, 8'hC0);
        pulse(PIN_B, 14, 8'h00);
        pulse(PIN_B, 49, 8'h02);
        wb(1'h1, IDX_MODE_CONFIG, 8'h04);
        pulse(PIN_F, 7, 8'h00);
        cdone <= 1'h1;
        pulse(PIN_C, 1, 8'h20);
        cdone <= 1'h0;
        wb(1'h1, IDX_IRQ_LATCH, 8'h3F);
        wb(1'h1, IDX_MODE_CONFIG, 8'h01);
        pulse(PIN_C, 3, 8'h00);
        pulse(PIN_C, 14, 8'h04);
        wb(1'h1, IDX_MODE_CONFIG, 8'h00);
        pins[PIN_A] <= 1'h0;
        repeat (13) @(posedge clk_i);
        wb(1'h0, IDX_IRQ_LATCH, 8'h00);
        check(got, 32'h1);
        pins[PIN_A] <= 1'h1;
        wb(1'h1, IDX_IRQ_LATCH, 8'h3F);
        t_pin_e_modes();
        t_edge_sel();
        wb(1'h1, IDX_EXT_IRQ_CONTROL, 8'h40);
        wb(1'h1, IDX_IRQ_ENABLE, 8'h03);
        dly <= 4'h2;
        pulse(PIN_A, 7, 8'h00);
        wb(1'h0, IDX_IRQ_ENABLE, 8'h00);
        check(got, 32'h2);
        t_traps();
        stop_test();
    end
endmodule
`default_nettype wire
